/* File: hw/acts_top.sv */
// conversion timing sequencer with avalon register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module acts_top
   import acts_pkg::*;
#(
   parameter int MCLK_DIV = CLK_PER_MCLK,
   parameter logic [TW-1:0] P_POST1 = POST1_CYC,
   parameter logic [TW-1:0] P_POST2 = POST2_CYC,
   parameter logic [TW-1:0] P_POST3 = POST3_CYC,
   parameter logic [TW-1:0] P_POST4 = POST4_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // converter control
   output logic mod_reset,
   output logic [CHW-1:0] input_crosspoint,
   output logic conv_active,
   output logic drdy_n
);
   acts_setup_if tim();
   acts_state_t state_ff, nxt_state;
   logic wait_ff;
   logic [31:0] rdata_ff, rd_mux;
   logic [31:0] ctrl_ff;
   logic [31:0] setup_ff [NCH];
   logic [31:0] result_ff;
   logic [DIVW-1:0] div_ff;
   logic tick_ff;
   logic [CHW-1:0] cur_chan_ff, nxt_chan, res_chan_ff, xpt_ff;
   logic [3:0] rep_left_ff, nxt_rep;
   acts_setup_t cur_setup_ff;
   logic [SEQW-1:0] seq_ff;
   logic ph_load, ph_done, pp_load, pp_done;
   logic [TW-1:0] ph_val;
   logic drdy_n_ff, relow_ff, mod_reset_ff, act_ff;
   logic wr_fire, rd_fire, res_read, run;
   logic [NCH-1:0] chan_en;
   logic [TW-1:0] st_ticks_ff;

   // next enabled channel after from, nearest first, else from
   function automatic logic [CHW-1:0] next_en(input logic [CHW-1:0] from,
                                              input logic [NCH-1:0] en);
      logic [CHW-1:0] res;
      logic [CHW-1:0] c;
      res = from;
      for (int i = NCH - 1; i >= 1; i--) begin
         c = from + CHW'(i);
         if (en[c]) begin
            res = c;
         end
      end
      return res;
   endfunction

   // byte lane merge for register writes
   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // ==========================================================
   // bus slave: one wait cycle, then the answer
   assign wr_fire = avs_write && !wait_ff;
   assign rd_fire = avs_read && !wait_ff;
   assign res_read = rd_fire && (avs_address == ADDR_RESULT);
   assign run = ctrl_ff[CTRL_RUN_BIT];
   assign chan_en = ctrl_ff[CTRL_EN_LSB +: NCH];

   // read mux, unmapped reads give zero
   always_comb begin
      rd_mux = 32'h00000000;
      case (avs_address)
         ADDR_CTRL: rd_mux = ctrl_ff;
         ADDR_STATUS: begin
            rd_mux[ST_ACT_BIT] = act_ff;
            rd_mux[ST_RDY_BIT] = !drdy_n_ff;
            rd_mux[ST_STATE_LSB +: 3] = state_ff;
            rd_mux[ST_CHAN_LSB +: CHW] = cur_chan_ff;
         end
         ADDR_RESULT: rd_mux = result_ff;
         default: begin
            for (int n = 0; n < NCH; n++) begin
               if (avs_address == ADDR_SETUP0 + 5'(4 * n)) begin
                  rd_mux = setup_ff[n];
               end
            end
         end
      endcase
   end

   // waitrequest handshake and read data capture
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h00000000;
      end else if (!wait_ff) begin
         wait_ff <= 1'b1;
      end else if (avs_read || avs_write) begin
         wait_ff <= 1'b0;
         rdata_ff <= avs_read ? rd_mux : 32'h00000000;
      end
   end

   // register writes take effect at the completing edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_ff <= CTRL_RST;
         for (int n = 0; n < NCH; n++) begin
            setup_ff[n] <= SETUP_RST;
         end
      end else if (wr_fire) begin
         if (avs_address == ADDR_CTRL) begin
            ctrl_ff <= be_merge(ctrl_ff, avs_writedata, avs_byteenable);
         end
         for (int n = 0; n < NCH; n++) begin
            if (avs_address == ADDR_SETUP0 + 5'(4 * n)) begin
               setup_ff[n] <= be_merge(setup_ff[n], avs_writedata,
                                       avs_byteenable);
            end
         end
      end
   end

   // ==========================================================
   // master clock tick from the system clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_ff <= '0;
         tick_ff <= 1'b0;
      end else if (div_ff == DIVW'(MCLK_DIV - 1)) begin
         div_ff <= '0;
         tick_ff <= 1'b1;
      end else begin
         div_ff <= div_ff + DIVW'(1);
         tick_ff <= 1'b0;
      end
   end

   // ==========================================================
   // timing of the channel now converting
   assign tim.setup = cur_setup_ff;
   acts_timing #(
      .P_POST1(P_POST1),
      .P_POST2(P_POST2),
      .P_POST3(P_POST3),
      .P_POST4(P_POST4)
   ) u_timing (
      .tim(tim.calc)
   );

   // settle and conversion phase counter
   acts_downcnt #(.W(TW)) u_phase (
      .clk(clk),
      .nrst(nrst),
      .load(ph_load),
      .load_val(ph_val),
      .tick(tick_ff),
      .done(ph_done)
   );

   // postprocess counter runs beside the next channel's settling
   acts_downcnt #(.W(TW)) u_pp (
      .clk(clk),
      .nrst(nrst),
      .load(pp_load),
      .load_val(tim.pp_cyc),
      .tick(tick_ff),
      .done(pp_done)
   );

   // ==========================================================
   // sequencer state machine
   always_comb begin
      nxt_state = state_ff;
      nxt_chan = cur_chan_ff;
      nxt_rep = rep_left_ff;
      ph_load = 1'b0;
      ph_val = '0;
      pp_load = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (run && chan_en != '0) begin
               nxt_chan = next_en(CHW'(NCH - 1), chan_en);
               nxt_state = ST_SWITCH;
            end
         end
         ST_SWITCH: begin
            nxt_state = ST_SETTLE_LD;
         end
         ST_SETTLE_LD: begin
            ph_load = 1'b1;
            ph_val = tim.settle_cyc;
            nxt_state = ST_SETTLE;
         end
         ST_SETTLE: begin
            if (ph_done) begin
               ph_load = 1'b1;
               ph_val = tim.first_cyc;
               nxt_state = ST_CONVERT;
            end
         end
         ST_CONVERT: begin
            if (ph_done) begin
               pp_load = 1'b1;
               if (rep_left_ff != 4'h0 ||
                   next_en(cur_chan_ff, chan_en) == cur_chan_ff) begin
                  ph_load = 1'b1;
                  ph_val = tim.tcnv_cyc;
                  if (rep_left_ff != 4'h0) begin
                     nxt_rep = rep_left_ff - 4'h1;
                  end
               end else begin
                  nxt_chan = next_en(cur_chan_ff, chan_en);
                  nxt_state = ST_SWITCH;
               end
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      if (!run) begin
         nxt_state = ST_IDLE;
      end
   end

   // state, channel and latched setup
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ST_IDLE;
         cur_chan_ff <= '0;
         rep_left_ff <= 4'h0;
         cur_setup_ff <= '0;
         res_chan_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cur_chan_ff <= nxt_chan;
         rep_left_ff <= nxt_rep;
         if (state_ff == ST_SWITCH) begin
            cur_setup_ff.filt <= setup_ff[cur_chan_ff][SET_FILT_LSB +: 4];
            cur_setup_ff.settle <= setup_ff[cur_chan_ff][SET_SETTLE_LSB +: 3];
            cur_setup_ff.speed <= setup_ff[cur_chan_ff][SET_SPD_LSB +: SPW];
            rep_left_ff <= setup_ff[cur_chan_ff][SET_REP_LSB +: 4];
         end
         if (pp_load) begin
            res_chan_ff <= cur_chan_ff;
         end
      end
   end

   // front end control: reset pulse and crosspoint on a switch
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mod_reset_ff <= 1'b0;
         xpt_ff <= '0;
         act_ff <= 1'b0;
      end else begin
         mod_reset_ff <= (state_ff == ST_SWITCH);
         if (state_ff == ST_SWITCH) begin
            xpt_ff <= cur_chan_ff;
         end
         act_ff <= (nxt_state == ST_CONVERT);
      end
   end

   // ==========================================================
   // data ready and result word; a new result beats a read release
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         drdy_n_ff <= 1'b1;
         relow_ff <= 1'b0;
         result_ff <= 32'h00000000;
         seq_ff <= '0;
      end else if (pp_done) begin
         drdy_n_ff <= !drdy_n_ff;
         relow_ff <= !drdy_n_ff;
         seq_ff <= seq_ff + SEQW'(1);
         result_ff <= {seq_ff, {(RES_SEQ_LSB - CHW){1'b0}}, res_chan_ff};
      end else if (relow_ff) begin
         drdy_n_ff <= 1'b0;
         relow_ff <= 1'b0;
      end else if (res_read) begin
         drdy_n_ff <= 1'b1;
      end
   end

   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign mod_reset = mod_reset_ff;
   assign input_crosspoint = xpt_ff;
   assign conv_active = act_ff;
   assign drdy_n = drdy_n_ff;

   // ==========================================================
   // checks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_ticks_ff <= '0;
      end else if (state_ff != ST_SETTLE) begin
         st_ticks_ff <= '0;
      end else if (tick_ff) begin
         st_ticks_ff <= st_ticks_ff + TW'(1);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   AST_SWITCH_RESET: assert property (
      state_ff == ST_SWITCH |=> mod_reset_ff && xpt_ff == cur_chan_ff)
      else $error("no front end reset on channel switch");
   AST_SETTLE_MIN: assert property (
      state_ff == ST_SETTLE_LD |-> tim.settle_cyc >= SETTLE_MIN)
      else $error("settle shorter than minimum");
   AST_SETTLE_LEN: assert property (
      state_ff == ST_SETTLE && ph_done |->
      st_ticks_ff + TW'(1) == tim.settle_cyc ##1 state_ff == ST_CONVERT)
      else $error("settle length wrong");
   AST_FIRST_SINC4: assert property (
      tim.setup.filt == F_SINC4 |-> tim.first_cyc == ORDER4 * tim.tcnv_cyc)
      else $error("sinc4 first result time wrong");
   AST_PERIOD_AVG: assert property (
      tim.setup.filt == F_SINC4_AVG && tim.setup.speed != '0 |->
      tim.tcnv_cyc == TW'(tim.setup.speed) * AVG4_MULT)
      else $error("averaged period wrong");
   AST_PP_STD: assert property (
      tim.setup.filt == F_SINC3 && tim.setup.speed <= 11'h001 |->
      tim.pp_cyc == PP_SHORT)
      else $error("short postprocess delay wrong");
   AST_PP_POST: assert property (
      tim.setup.filt == F_POST2 |-> tim.pp_cyc == PP_POST)
      else $error("post filter postprocess delay wrong");
   AST_DRDY_FALL: assert property (
      pp_done && drdy_n_ff |=> !drdy_n_ff && result_ff[1:0] == res_chan_ff)
      else $error("ready did not fall after postprocess");
   AST_DRDY_RELOW: assert property (
      pp_done && !drdy_n_ff |=> drdy_n_ff ##1 !drdy_n_ff)
      else $error("back to back result lost its edge");
   AST_READ_RELEASE: assert property (
      res_read && !pp_done && !relow_ff |=> drdy_n_ff)
      else $error("result read did not release ready");
endmodule
`default_nettype wire

/* File: hw/acts_pkg.sv */
// constants, types and register map of the conversion timing sequencer
// ==========================================================
// Summary of operation
// - channel change resets modulator and filter, switches crosspoint, then settles
// - settling before the first conversion is never shorter than 32 cycles
// - settle code 0 gives 32 cycles, doubling per step to 4096; default 0
// - first result after 4, 3 or 1 conversion periods by filter type
// - period is 32, 352 or 320 times the speed word by sinc filter type; post filters use fixed periods
// - standalone sinc postprocess 28 cycles at speed 0 or 1, else 62
// - post filters always postprocess in 69 cycles
// - first result time is settle plus ideal first time plus postprocess
// - later results on the same channel come once per conversion period
// - each channel converts with its own setup
// - switch channel at conversion end; ready falls after postprocess delay
// - ready spacing is first time minus previous channel postprocess delay
// - shared setup, repeat zero gives one result per settle plus ideal time
// - filter behaviour depends only on filter type and speed word
// - averaging factor 8: period is order plus seven times 32 times speed
// - speed word is an 11-bit unsigned value used directly, except that zero runs as one
// - all counts run on the 76.8 kHz master clock
// - with several channels enabled the sequencer steps through them alone
package acts_pkg;
   // ==========================================================
   // clocks
   localparam int CLK_HZ = 40_000_000;
   localparam int MCLK_HZ = 76_800;
   localparam int CLK_PER_MCLK = CLK_HZ / MCLK_HZ;
   localparam int DIVW = 16;
   // ==========================================================
   // sizes
   localparam int NCH = 4;
   localparam int CHW = 2;
   localparam int SPW = 11;
   localparam int TW = 20;
   localparam int SEQW = 16;
   // ==========================================================
   // timing figures in master clock cycles
   localparam logic [TW-1:0] SETTLE_BASE = 20'h00020;
   localparam logic [TW-1:0] SETTLE_MIN = 20'h00020;
   localparam logic [TW-1:0] CNV_BASE = 20'h00020;
   localparam int AVG_FACTOR = 8;
   localparam logic [TW-1:0] AVG4_MULT = TW'((4 + AVG_FACTOR - 1) * 32);
   localparam logic [TW-1:0] AVG3_MULT = TW'((3 + AVG_FACTOR - 1) * 32);
   localparam logic [TW-1:0] ORDER4 = 20'h00004;
   localparam logic [TW-1:0] ORDER3 = 20'h00003;
   localparam logic [TW-1:0] PP_SHORT = 20'h0001c;
   localparam logic [TW-1:0] PP_LONG = 20'h0003e;
   localparam logic [TW-1:0] PP_POST = 20'h00045;
   localparam logic [TW-1:0] POST1_CYC = 20'h00b80;
   localparam logic [TW-1:0] POST2_CYC = 20'h00c80;
   localparam logic [TW-1:0] POST3_CYC = 20'h00f80;
   localparam logic [TW-1:0] POST4_CYC = 20'h01280;
   // ==========================================================
   // register map, byte addresses
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_STATUS = 5'h04;
   localparam logic [4:0] ADDR_RESULT = 5'h08;
   localparam logic [4:0] ADDR_SETUP0 = 5'h10;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_EN_LSB = 4;
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   localparam int SET_SPD_LSB = 0;
   localparam int SET_SETTLE_LSB = 12;
   localparam int SET_FILT_LSB = 16;
   localparam int SET_REP_LSB = 24;
   localparam logic [31:0] SETUP_RST = 32'h00000001;
   localparam int ST_ACT_BIT = 0;
   localparam int ST_RDY_BIT = 1;
   localparam int ST_STATE_LSB = 4;
   localparam int ST_CHAN_LSB = 8;
   localparam int RES_CHAN_LSB = 0;
   localparam int RES_SEQ_LSB = 16;
   // ==========================================================
   // types
   typedef enum logic [3:0] {
      F_SINC4, F_SINC4_AVG, F_SINC3, F_SINC3_NOTCH, F_SINC3_AVG,
      F_POST1, F_POST2, F_POST3, F_POST4
   } acts_filt_t;
   typedef enum logic [2:0] {
      ST_IDLE, ST_SWITCH, ST_SETTLE_LD, ST_SETTLE, ST_CONVERT
   } acts_state_t;
   typedef struct packed {
      logic [3:0] filt;
      logic [2:0] settle;
      logic [SPW-1:0] speed;
   } acts_setup_t;
endpackage

/* File: hw/acts_setup_if.sv */
// carrier between the sequencer and its timing calculator
`timescale 1ns/1ps
`default_nettype none
interface acts_setup_if;
   import acts_pkg::*;
   acts_setup_t setup;
   logic [TW-1:0] settle_cyc;
   logic [TW-1:0] tcnv_cyc;
   logic [TW-1:0] first_cyc;
   logic [TW-1:0] pp_cyc;
   modport calc(input setup, output settle_cyc, tcnv_cyc, first_cyc, pp_cyc);
   modport user(output setup, input settle_cyc, tcnv_cyc, first_cyc, pp_cyc);
endinterface
`default_nettype wire

/* File: hw/acts_timing.sv */
// timing calculator: settle, period, first result and postprocess cycles
`timescale 1ns/1ps
`default_nettype none
module acts_timing
   import acts_pkg::*;
#(
   parameter logic [TW-1:0] P_POST1 = POST1_CYC,
   parameter logic [TW-1:0] P_POST2 = POST2_CYC,
   parameter logic [TW-1:0] P_POST3 = POST3_CYC,
   parameter logic [TW-1:0] P_POST4 = POST4_CYC
) (
   // setup in, cycle counts out
   acts_setup_if.calc tim
);
   logic [TW-1:0] spd;
   logic [TW-1:0] base;
   // ==========================================================
   // speed word taken as plain unsigned, zero run as one
   assign spd = (tim.setup.speed == '0) ? 20'h00001
                : TW'(tim.setup.speed);
   assign base = spd * CNV_BASE;
   assign tim.settle_cyc = SETTLE_BASE << tim.setup.settle;
   // ==========================================================
   // period, first result and postprocess per filter type and speed word
   // notch placement follows filter and speed alone
   always_comb begin
      tim.tcnv_cyc = base;
      tim.first_cyc = base * ORDER4;
      tim.pp_cyc = (spd > 20'h00001) ? PP_LONG : PP_SHORT;
      case (tim.setup.filt)
         F_SINC3, F_SINC3_NOTCH: begin
            tim.first_cyc = base * ORDER3;
         end
         F_SINC4_AVG: begin
            tim.tcnv_cyc = spd * AVG4_MULT;
            tim.first_cyc = spd * AVG4_MULT;
            tim.pp_cyc = PP_LONG;
         end
         F_SINC3_AVG: begin
            tim.tcnv_cyc = spd * AVG3_MULT;
            tim.first_cyc = spd * AVG3_MULT;
            tim.pp_cyc = PP_LONG;
         end
         F_POST1, F_POST2, F_POST3, F_POST4: begin
            case (tim.setup.filt)
               F_POST1: tim.tcnv_cyc = P_POST1;
               F_POST2: tim.tcnv_cyc = P_POST2;
               F_POST3: tim.tcnv_cyc = P_POST3;
               default: tim.tcnv_cyc = P_POST4;
            endcase
            tim.first_cyc = tim.tcnv_cyc;
            tim.pp_cyc = PP_POST;
         end
         default: begin
            tim.tcnv_cyc = base;
         end
      endcase
   end
endmodule
`default_nettype wire

/* File: hw/acts_downcnt.sv */
// tick driven down counter that pulses done on the last tick
`timescale 1ns/1ps
`default_nettype none
module acts_downcnt #(
   parameter int W = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // control
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic tick,
   output logic done
);
   logic [W-1:0] cnt_ff;
   // ==========================================================
   // count down one per tick, load wins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff <= '0;
      end else if (load) begin
         cnt_ff <= load_val;
      end else if (tick && cnt_ff != '0) begin
         cnt_ff <= cnt_ff - W'(1);
      end
   end
   // done must not look at load: callers reload in answer to done
   assign done = tick && (cnt_ff == W'(1));
endmodule
`default_nettype wire

/* File: tb/acts_host_model.sv */
// host model: avalon master and recorder of ready falling edges
`timescale 1ns/1ps
`default_nettype none
module acts_host_model (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // avalon-mm master
   output var logic [4:0] avs_address,
   output var logic avs_read,
   output var logic avs_write,
   output var logic [31:0] avs_writedata,
   output var logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // result indication
   input wire logic drdy_n
);
   int cyc = 0;
   int falls[$];
   logic prev_ff = 1'b1;
   initial begin
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end
   // one access, held until waitrequest is sampled low
   task automatic access(input logic wr, input logic [4:0] a,
         input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_byteenable <= 4'hf;
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // each falling ready edge is taken as one new result
   always @(posedge clk) begin
      cyc <= cyc + 1;
      prev_ff <= drdy_n;
      if (prev_ff === 1'b1 && drdy_n === 1'b0) falls.push_back(cyc);
   end
endmodule
`default_nettype wire

/* File: tb/adc_conversion_timing_sequencer_test.sv */
// self-checking bench of the conversion timing sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_timing_sequencer_test;
   import acts_pkg::*;
   localparam int DIV = 4;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic mod_reset;
   logic [CHW-1:0] input_crosspoint;
   logic conv_active;
   logic drdy_n;
   logic [31:0] d;
   int mismatches = 0;
   int compares = 0;
   int switches = 0;
   // ==========================================================
   // clock, design and host
   always #12.5 clk = ~clk;
   always @(posedge clk) if (mod_reset === 1'b1) switches <= switches + 1;
   acts_top #(.MCLK_DIV(DIV), .P_POST1(20'h00050), .P_POST2(20'h00058),
      .P_POST3(20'h00060), .P_POST4(20'h00068)) i_dut (.clk, .nrst,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .mod_reset, .input_crosspoint,
      .conv_active, .drdy_n);
   acts_host_model i_host (.clk, .nrst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .drdy_n);
   // ==========================================================
   // compares and expected timing
   task automatic chk(input string s, input logic [31:0] e,
         input logic [31:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic chk_t(input string s, input int e, input int g, input int t);
      compares++;
      if (g < e - t || g > e + t) begin
         mismatches++;
         $display("Error %s expected %0d seen %0d", s, e, g);
      end
   endtask
   // post periods are the shortened bench values, longer than 69
   function automatic int tcnv(input int f, input int spd);
      case (f)
         1: return 352 * spd;
         4: return 320 * spd;
         5: return 80;
         6: return 88;
         7: return 96;
         8: return 104;
         default: return 32 * spd;
      endcase
   endfunction
   function automatic int ppd(input int f, input int spd);
      if (f > 4 && f < 9) return 69;
      return (f == 1 || f == 4 || spd > 1) ? 62 : 28;
   endfunction
   // unknown filter codes time as sinc4
   function automatic int t1st(input int f, input int spd, input int c);
      int n;
      n = (f == 0 || f > 8) ? 4 : (f == 2 || f == 3) ? 3 : 1;
      return (32 << c) + n * tcnv(f, spd) + ppd(f, spd);
   endfunction
   function automatic int fl(input int i);
      return i_host.falls[i];
   endfunction
   // ==========================================================
   // bus helpers
   task automatic bus(input logic wr, input logic [4:0] a, input int v);
      i_host.access(wr, a, 32'(v), d);
   endtask
   task automatic setup(input int n, input int f, input int spd, input int c);
      bus(1'b1, ADDR_SETUP0 + 5'(4 * n), (f << 16) | (c << 12) | spd);
   endtask
   task automatic start(input int ctrl, input int n, output int t0);
      i_host.falls.delete();
      bus(1'b1, ADDR_CTRL, ctrl);
      t0 = i_host.cyc;
      for (int k = 0; k < 80000 && i_host.falls.size() < n; k++) @(posedge clk);
   endtask
   task automatic stop();
      bus(1'b1, ADDR_CTRL, 0);
      bus(1'b0, ADDR_RESULT, 0);
      #1 chk("ready released", 32'h1, 32'(drdy_n));
   endtask
   // ==========================================================
   // scenarios
   task automatic regs();
      bus(1'b0, ADDR_CTRL, 0);
      chk("ctrl reset", CTRL_RST, d);
      bus(1'b0, ADDR_SETUP0 + 5'h0c, 0);
      chk("setup reset", SETUP_RST, d);
      bus(1'b1, 5'h0c, -1);
      bus(1'b0, 5'h0c, 0);
      chk("unmapped", 32'h0, d);
      bus(1'b1, ADDR_STATUS, -1);
      bus(1'b0, ADDR_STATUS, 0);
      chk("status idle", 32'h0, d);
   endtask
   // one channel: first result and steady period
   task automatic one(input int f, input int spd, input int c);
      int t0;
      int m;
      m = switches;
      setup(0, f, spd, c);
      start(32'h11, 3, t0);
      chk_t("first result", DIV * t1st(f, spd, c), fl(0) - t0, 8);
      chk_t("period", DIV * tcnv(f, spd), fl(2) - fl(1), 0);
      chk("converting", 32'h1, 32'(conv_active));
      chk("switches", 32'h1, 32'(switches - m));
      stop();
   endtask
   // two channels: gaps between ready edges; ends back on channel 0
   task automatic seq(input int f, input int spd, input int c);
      int t0;
      setup(0, 0, 1, 0);
      setup(1, f, spd, c);
      start(32'h31, 4, t0);
      chk_t("ch0 gap", DIV * (188 - ppd(f, spd)), fl(2) - fl(1),
         8);
      chk_t("ch1 gap", DIV * (t1st(f, spd, c) - 28), fl(3) - fl(2),
         8);
      chk("crosspoint", 32'h0, 32'(input_crosspoint));
      stop();
      chk("result chan", 32'h1, d & 32'h3);
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      regs();
      one(0, 1, 0);
      for (int f = 0; f < 10; f++) one(f, 2, f % 8);
      seq(2, 2, 1);
      seq(0, 1, 0);
      give_verdict();
   end
   initial begin
      repeat (95000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire
